// >>> core/ref_pkg.sv
// Constants and types shared by the restricted earth-fault trip block
package ref_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_BASE = 8'h04;
  localparam logic [7:0] ADDR_SLOPE = 8'h08;
  localparam logic [7:0] ADDR_BRK = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_DIFF = 8'h14;
  localparam logic [7:0] ADDR_BIAS = 8'h18;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h1c;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h20;
  localparam int CTRL_OPER_BIT = 0;
  localparam int CTRL_DIRCHK_BIT = 1;
  localparam logic OPER_RST = 1'b1;
  localparam logic DIRCHK_RST = 1'b1;
  localparam logic [6:0] BASE_MIN = 7'h0a;
  localparam logic [6:0] BASE_MAX = 7'h32;
  localparam logic [6:0] BASE_RST = 7'h1e;
  localparam logic [6:0] SLOPE_MIN = 7'h32;
  localparam logic [6:0] SLOPE_MAX = 7'h64;
  localparam logic [6:0] SLOPE_RST = 7'h46;
  localparam logic [7:0] BRK_MIN = 8'h64;
  localparam logic [7:0] BRK_MAX = 8'hc8;
  localparam logic [7:0] BRK_RST = 8'h7d;
  localparam logic [3:0] DESENS_FACTOR = 4'h4;
  localparam logic [6:0] PCT_SCALE = 7'h64;
  localparam int ST_TRIP_BIT = 0;
  localparam int ST_CHAR_BIT = 1;
  localparam int ST_DIRBLK_BIT = 2;
  localparam int ST_USRBLK_BIT = 3;
  localparam int IRQ_W = 2;
  localparam int IRQ_TRIP_BIT = 0;
  localparam int IRQ_CHAR_BIT = 1;
  localparam logic [1:0] IRQ_MASK_RST = 2'h0;
  typedef enum logic [1:0] {
    REF_RESP_OKAY = 2'b00,
    REF_RESP_SLVERR = 2'b10
  } ref_resp_t;
  typedef struct packed {
    logic oper;
    logic dir_chk;
    logic [6:0] base;
    logic [6:0] slope;
    logic [7:0] brk;
  } ref_cfg_t;
endpackage

// >>> core/ref_char_eval.sv
// Differential, bias and characteristic comparison, purely combinational
`timescale 1ns/1ps
module ref_char_eval #(
  parameter int DW = 16
) (
  input wire logic [DW-1:0] phase1_fund_i,
  input wire logic [DW-1:0] phase2_fund_i,
  input wire logic [DW-1:0] phase3_fund_i,
  input wire logic [DW-1:0] neutral_fund_i,
  input wire ref_pkg::ref_cfg_t cfg_i,
  input wire logic desensitise_in_i,
  output logic [DW+1:0] diff_sum_o,
  output logic [DW-1:0] bias_max_o,
  output logic [8:0] base_eff_o,
  output logic above_o
);
  localparam int CW = DW + 10;
  logic [DW-1:0] max_a;
  logic [DW-1:0] max_b;
  logic [DW-1:0] brk_w;
  logic [DW-1:0] excess;
  logic [CW-1:0] lhs;
  logic [CW-1:0] rhs;

  assign diff_sum_o = {2'b00, phase1_fund_i} + {2'b00, phase2_fund_i}
                    + {2'b00, phase3_fund_i} + {2'b00, neutral_fund_i};
  assign max_a = (phase1_fund_i >= phase2_fund_i) ? phase1_fund_i : phase2_fund_i;
  assign max_b = (phase3_fund_i >= neutral_fund_i) ? phase3_fund_i : neutral_fund_i;
  assign bias_max_o = (max_a >= max_b) ? max_a : max_b;
  assign base_eff_o = desensitise_in_i ?
      9'({2'b00, cfg_i.base} * {5'h00, ref_pkg::DESENS_FACTOR}) : {2'b00, cfg_i.base};
  assign brk_w = DW'(cfg_i.brk);
  // Above the breakpoint the threshold rises with the excess bias only
  assign excess = (bias_max_o > brk_w) ? bias_max_o - brk_w : '0;
  // Both sides scaled by 100 so the slope percentage needs no divider
  assign lhs = CW'(diff_sum_o) * CW'(ref_pkg::PCT_SCALE);
  assign rhs = CW'(base_eff_o) * CW'(ref_pkg::PCT_SCALE)
             + CW'(cfg_i.slope) * CW'(excess);
  assign above_o = lhs > rhs;
endmodule // ref_char_eval

// >>> core/ref_trip_top.sv
// Restricted earth-fault trip block with AXI4-Lite settings and interrupt
// Notes on behaviour
// - Differential is sum of four fundamentals
// - Bias is largest of four fundamentals
// - Base sensitivity 10..50 percent, default 30
// - Slope 50..100 percent of bias, default 70
// - Breakpoint bias 100..200 percent, default 125
// - Desensitise input multiplies base sensitivity by four
// - Differential and bias output as percent values
// - Internal trip flag when differential above curve
// - Trip needs flag, no blocking, operation on
// - Directional start blocks only when check enabled
// - User block input always suppresses trip
// - Operation setting Off or On, default On
// - Directional check setting defaults to true
//
// The implementer's own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
module ref_trip_top #(
  parameter int DW = 16
) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [DW-1:0] phase1_fund_i,
  input wire logic [DW-1:0] phase2_fund_i,
  input wire logic [DW-1:0] phase3_fund_i,
  input wire logic [DW-1:0] neutral_fund_i,
  input wire logic sample_valid_i,
  input wire logic desensitise_in_i,
  input wire logic user_block_in_i,
  input wire logic dir_block_start_i,
  output logic general_trip_out_o,
  output logic char_trip_internal_o,
  output logic [DW+1:0] diff_measured_o,
  output logic [DW-1:0] bias_measured_o,
  output logic irq_o
);
  generate
    if (DW < 8 || DW > 29) begin : g_bad_dw
      $error("DW must lie between 8 and 29");
    end
  endgenerate

  ref_pkg::ref_cfg_t cfg;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic w_lane0;
  logic do_write;
  logic wr_ok;
  logic [ref_pkg::IRQ_W-1:0] irq_stat;
  logic [ref_pkg::IRQ_W-1:0] irq_mask;
  logic [ref_pkg::IRQ_W-1:0] irq_ev;
  logic [ref_pkg::IRQ_W-1:0] irq_clr;
  logic [ref_pkg::IRQ_W-1:0] next_irq_stat;
  logic [DW+1:0] diff_sum;
  logic [DW-1:0] bias_max;
  logic [8:0] base_eff;
  logic above;
  logic blocked;
  logic next_trip;
  logic next_char;
  logic [31:0] rd_word;
  logic rd_hit;

  ref_char_eval #(.DW(DW)) u_eval (
    .phase1_fund_i(phase1_fund_i),
    .phase2_fund_i(phase2_fund_i),
    .phase3_fund_i(phase3_fund_i),
    .neutral_fund_i(neutral_fund_i),
    .cfg_i(cfg),
    .desensitise_in_i(desensitise_in_i),
    .diff_sum_o(diff_sum),
    .bias_max_o(bias_max),
    .base_eff_o(base_eff),
    .above_o(above)
  );

  // Write address and data are caught independently, in either order
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      s_axi_awready_o <= 1'b1;
      aw_addr <= 8'h00;
    end else if (s_axi_awvalid_i && s_axi_awready_o) begin
      s_axi_awready_o <= 1'b0;
      aw_addr <= s_axi_awaddr_i;
    end else if (do_write) begin
      s_axi_awready_o <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      s_axi_wready_o <= 1'b1;
      w_data <= 32'h0000_0000;
      w_lane0 <= 1'b0;
    end else if (s_axi_wvalid_i && s_axi_wready_o) begin
      s_axi_wready_o <= 1'b0;
      w_data <= s_axi_wdata_i;
      w_lane0 <= s_axi_wstrb_i[0];
    end else if (do_write) begin
      s_axi_wready_o <= 1'b1;
    end
  end

  assign do_write = !s_axi_awready_o && !s_axi_wready_o && !s_axi_bvalid_o;

  // Out-of-range settings are refused whole so the curve never leaves its span
  always_comb begin
    wr_ok = 1'b1;
    if (aw_addr == ref_pkg::ADDR_CTRL || aw_addr == ref_pkg::ADDR_IRQ_STAT
        || aw_addr == ref_pkg::ADDR_IRQ_MASK) begin
      wr_ok = 1'b1;
    end else if (aw_addr == ref_pkg::ADDR_BASE) begin
      wr_ok = w_data[31:7] == 25'h0 && w_data[6:0] >= ref_pkg::BASE_MIN
              && w_data[6:0] <= ref_pkg::BASE_MAX;
    end else if (aw_addr == ref_pkg::ADDR_SLOPE) begin
      wr_ok = w_data[31:7] == 25'h0 && w_data[6:0] >= ref_pkg::SLOPE_MIN
              && w_data[6:0] <= ref_pkg::SLOPE_MAX;
    end else if (aw_addr == ref_pkg::ADDR_BRK) begin
      wr_ok = w_data[31:8] == 24'h0 && w_data[7:0] >= ref_pkg::BRK_MIN
              && w_data[7:0] <= ref_pkg::BRK_MAX;
    end else begin
      wr_ok = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= ref_pkg::REF_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o <= wr_ok ? ref_pkg::REF_RESP_OKAY : ref_pkg::REF_RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      cfg.oper <= ref_pkg::OPER_RST;
      cfg.dir_chk <= ref_pkg::DIRCHK_RST;
      cfg.base <= ref_pkg::BASE_RST;
      cfg.slope <= ref_pkg::SLOPE_RST;
      cfg.brk <= ref_pkg::BRK_RST;
      irq_mask <= ref_pkg::IRQ_MASK_RST;
    end else if (do_write && wr_ok && w_lane0) begin
      if (aw_addr == ref_pkg::ADDR_CTRL) begin
        cfg.oper <= w_data[ref_pkg::CTRL_OPER_BIT];
        cfg.dir_chk <= w_data[ref_pkg::CTRL_DIRCHK_BIT];
      end else if (aw_addr == ref_pkg::ADDR_BASE) begin
        cfg.base <= w_data[6:0];
      end else if (aw_addr == ref_pkg::ADDR_SLOPE) begin
        cfg.slope <= w_data[6:0];
      end else if (aw_addr == ref_pkg::ADDR_BRK) begin
        cfg.brk <= w_data[7:0];
      end else if (aw_addr == ref_pkg::ADDR_IRQ_MASK) begin
        irq_mask <= w_data[ref_pkg::IRQ_W-1:0];
      end
    end
  end

  // Characteristic and measured values refresh only on a new input update
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      char_trip_internal_o <= 1'b0;
      diff_measured_o <= '0;
      bias_measured_o <= '0;
    end else if (sample_valid_i) begin
      char_trip_internal_o <= above;
      diff_measured_o <= diff_sum;
      bias_measured_o <= bias_max;
    end
  end

  // Inputs are already compensated, so one unit is one percent
  assign blocked = user_block_in_i || (cfg.dir_chk && dir_block_start_i);
  assign next_trip = char_trip_internal_o && !blocked && cfg.oper;
  assign next_char = sample_valid_i ? above : char_trip_internal_o;

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      general_trip_out_o <= 1'b0;
    end else begin
      general_trip_out_o <= next_trip;
    end
  end

  // A new event in the clearing cycle survives the clear
  assign irq_ev[ref_pkg::IRQ_TRIP_BIT] = next_trip && !general_trip_out_o;
  assign irq_ev[ref_pkg::IRQ_CHAR_BIT] = next_char && !char_trip_internal_o;
  assign irq_clr = (do_write && w_lane0 && aw_addr == ref_pkg::ADDR_IRQ_STAT) ?
                   w_data[ref_pkg::IRQ_W-1:0] : '0;
  assign next_irq_stat = (irq_stat & ~irq_clr) | irq_ev;

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      irq_stat <= '0;
      irq_o <= 1'b0;
    end else begin
      irq_stat <= next_irq_stat;
      irq_o <= |(next_irq_stat & irq_mask);
    end
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    if (s_axi_araddr_i == ref_pkg::ADDR_CTRL) begin
      rd_word[ref_pkg::CTRL_OPER_BIT] = cfg.oper;
      rd_word[ref_pkg::CTRL_DIRCHK_BIT] = cfg.dir_chk;
    end else if (s_axi_araddr_i == ref_pkg::ADDR_BASE) begin
      rd_word[6:0] = cfg.base;
    end else if (s_axi_araddr_i == ref_pkg::ADDR_SLOPE) begin
      rd_word[6:0] = cfg.slope;
    end else if (s_axi_araddr_i == ref_pkg::ADDR_BRK) begin
      rd_word[7:0] = cfg.brk;
    end else if (s_axi_araddr_i == ref_pkg::ADDR_STATUS) begin
      rd_word[ref_pkg::ST_TRIP_BIT] = general_trip_out_o;
      rd_word[ref_pkg::ST_CHAR_BIT] = char_trip_internal_o;
      rd_word[ref_pkg::ST_DIRBLK_BIT] = cfg.dir_chk && dir_block_start_i;
      rd_word[ref_pkg::ST_USRBLK_BIT] = user_block_in_i;
    end else if (s_axi_araddr_i == ref_pkg::ADDR_DIFF) begin
      rd_word[DW+1:0] = diff_measured_o;
    end else if (s_axi_araddr_i == ref_pkg::ADDR_BIAS) begin
      rd_word[DW-1:0] = bias_measured_o;
    end else if (s_axi_araddr_i == ref_pkg::ADDR_IRQ_STAT) begin
      rd_word[ref_pkg::IRQ_W-1:0] = irq_stat;
    end else if (s_axi_araddr_i == ref_pkg::ADDR_IRQ_MASK) begin
      rd_word[ref_pkg::IRQ_W-1:0] = irq_mask;
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= ref_pkg::REF_RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o <= rd_word;
      s_axi_rresp_o <= rd_hit ? ref_pkg::REF_RESP_OKAY : ref_pkg::REF_RESP_SLVERR;
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
    end
  end

  // Checks
  localparam int CW = DW + 10;
  logic [CW-1:0] chk_rhs;
  assign chk_rhs = (bias_max > DW'(cfg.brk)) ?
      CW'(base_eff) * CW'(7'h64) + CW'(cfg.slope) * CW'(bias_max - DW'(cfg.brk)) :
      CW'(base_eff) * CW'(7'h64);

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);

  AST_DIFF_SUM: assert property (sample_valid_i |=>
      diff_measured_o == $past(diff_sum) && diff_measured_o == $past({2'b00, phase1_fund_i}
      + {2'b00, phase2_fund_i} + {2'b00, phase3_fund_i} + {2'b00, neutral_fund_i}))
    else $error("Differential is not the sum of the inputs");
  AST_BIAS_MAX: assert property (sample_valid_i |=>
      bias_measured_o >= $past(phase1_fund_i) && bias_measured_o >= $past(phase2_fund_i)
      && bias_measured_o >= $past(phase3_fund_i) && bias_measured_o >= $past(neutral_fund_i)
      && (bias_measured_o == $past(phase1_fund_i) || bias_measured_o == $past(phase2_fund_i)
      || bias_measured_o == $past(phase3_fund_i) || bias_measured_o == $past(neutral_fund_i)))
    else $error("Bias is not the largest input");
  AST_SET_RANGE: assert property (cfg.base >= ref_pkg::BASE_MIN
      && cfg.base <= ref_pkg::BASE_MAX && cfg.slope >= ref_pkg::SLOPE_MIN
      && cfg.slope <= ref_pkg::SLOPE_MAX && cfg.brk >= ref_pkg::BRK_MIN
      && cfg.brk <= ref_pkg::BRK_MAX)
    else $error("A setting left its allowed range");
  AST_DESENS_FLAT: assert property (sample_valid_i && desensitise_in_i
      && bias_max <= DW'(cfg.brk) |=> char_trip_internal_o == ($past(diff_sum)
      > $past({{(DW-5){1'b0}}, cfg.base, 2'b00})))
    else $error("Desensitised flat section threshold wrong");
  AST_SLOPE_CURVE: assert property (sample_valid_i
      |=> char_trip_internal_o == ($past(CW'(diff_sum) * CW'(7'h64)) > $past(chk_rhs)))
    else $error("Characteristic decision disagrees with the curve");
  AST_CHAR_HOLD: assert property (!sample_valid_i |=> $stable(char_trip_internal_o)
      && $stable(diff_measured_o) && $stable(bias_measured_o))
    else $error("Outputs changed without an input update");
  AST_TRIP_CAUSE: assert property (general_trip_out_o |-> $past(char_trip_internal_o)
      && $past(cfg.oper) && !$past(user_block_in_i))
    else $error("Trip without its three conditions");
  AST_USER_BLOCK: assert property (user_block_in_i |=> !general_trip_out_o)
    else $error("Trip while user block active");
  AST_DIR_BLOCK: assert property (cfg.dir_chk && dir_block_start_i |=> !general_trip_out_o)
    else $error("Trip while directional block active");
  AST_DIR_IGNORED: assert property (!cfg.dir_chk && !user_block_in_i && cfg.oper
      && char_trip_internal_o |=> general_trip_out_o)
    else $error("Directional start blocked with check disabled");
  AST_OPER_OFF: assert property (!cfg.oper |=> !general_trip_out_o)
    else $error("Trip with operation Off");
  AST_RESET_CLEAR: assert property (disable iff (1'b0) !resetn_i |=>
      !general_trip_out_o && !char_trip_internal_o && diff_measured_o == '0 && !irq_o)
    else $error("Outputs not cleared by reset");

  COV_TRIP: cover property (sample_valid_i && above ##1 !blocked && cfg.oper ##1 general_trip_out_o);
  COV_DESENS_BLOCK: cover property (sample_valid_i && desensitise_in_i && !above);
  COV_DIR_BLOCKED: cover property (char_trip_internal_o && cfg.dir_chk && dir_block_start_i);
  COV_IRQ: cover property (irq_o ##1 do_write && aw_addr == ref_pkg::ADDR_IRQ_STAT);
endmodule // ref_trip_top

// >>> verification/ref_src_model.sv
// Stand-in for the preparation stage and the user logic equations
`timescale 1ns/1ps
module ref_src_model #(
  parameter int DW = 16
) (
  input wire logic clk_i,
  output logic [DW-1:0] phase1_fund_o,
  output logic [DW-1:0] phase2_fund_o,
  output logic [DW-1:0] phase3_fund_o,
  output logic [DW-1:0] neutral_fund_o,
  output logic sample_valid_o,
  output logic desensitise_in_o,
  output logic user_block_in_o,
  output logic dir_block_start_o
);
  initial begin
    {phase1_fund_o, phase2_fund_o, phase3_fund_o, neutral_fund_o} = '0;
    {sample_valid_o, desensitise_in_o, user_block_in_o, dir_block_start_o} = 4'h0;
  end
  // One update strobe; magnitudes arrive already matched, 1 LSB = 1 percent
  task automatic send(input logic [DW-1:0] a, b, c, n, input logic ds, ub, dr);
    @(posedge clk_i);
    phase1_fund_o <= a;
    phase2_fund_o <= b;
    phase3_fund_o <= c;
    neutral_fund_o <= n;
    sample_valid_o <= 1'b1;
    desensitise_in_o <= ds;
    user_block_in_o <= ub;
    dir_block_start_o <= dr; // Start when angle leaves the +/-90 degree cone
    @(posedge clk_i);
    sample_valid_o <= 1'b0;
    // Stale after the strobe: show inverted values so late sampling is caught
    phase1_fund_o <= ~a;
    phase2_fund_o <= ~b;
    phase3_fund_o <= ~c;
    neutral_fund_o <= ~n;
    repeat (3) @(posedge clk_i);
  endtask
endmodule // ref_src_model

// >>> verification/ref_trip_top_tb.sv
// Self-checking bench for the restricted earth-fault trip block
`timescale 1ns/1ps
module ref_trip_top_tb;
  logic clk, resetn, awvalid, wvalid, bready, arvalid, rready, sv1, sv2;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  wire awready, wready, bvalid, arready, rvalid, sv, ds, ub, dr, trip, chr, irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [15:0] p1, p2, p3, pn, bias;
  wire [17:0] diff;
  int err_total = 0, num_checks = 0, seed = 99538;
  logic [1:0] q_b[$];
  logic [33:0] q_r[$];
  logic [34:0] q_m[$], q_t[$];
  int lo[3] = '{10, 50, 100};
  int hi[3] = '{50, 100, 200};

  ref_src_model #(.DW(16)) u_src (.clk_i(clk), .phase1_fund_o(p1), .phase2_fund_o(p2),
    .phase3_fund_o(p3), .neutral_fund_o(pn), .sample_valid_o(sv), .desensitise_in_o(ds),
    .user_block_in_o(ub), .dir_block_start_o(dr));
  ref_trip_top #(.DW(16)) DUT (.sys_clk_i(clk), .resetn_i(resetn), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .phase1_fund_i(p1), .phase2_fund_i(p2), .phase3_fund_i(p3),
    .neutral_fund_i(pn), .sample_valid_i(sv), .desensitise_in_i(ds), .user_block_in_i(ub),
    .dir_block_start_i(dr), .general_trip_out_o(trip), .char_trip_internal_o(chr),
    .diff_measured_o(diff), .bias_measured_o(bias), .irq_o(irq));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk_bus(input logic [33:0] e, g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic chk_sig(input logic [34:0] e, g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  // Levels are read at the falling edge, away from the edge that launches them
  task automatic chk_irq(input logic e);
    @(negedge clk);
    chk_sig(35'(e), 35'(irq));
    @(posedge clk);
  endtask

  task final_report;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Results are matched oldest-first against the notes left by the drivers
  always @(posedge clk) begin
    if (sv2 && q_t.size() > 0) chk_sig(q_t.pop_front(), 35'(trip));
    if (sv1 && q_m.size() > 0) chk_sig(q_m.pop_front(), {chr, diff, bias});
    if (bvalid && bready && q_b.size() > 0) chk_bus(34'(q_b.pop_front()), 34'(bresp));
    if (rvalid && rready && q_r.size() > 0) chk_bus(q_r.pop_front(), {rresp, rdata});
    sv2 = sv1;
    sv1 = sv;
  end

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    q_b.push_back(er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid && n < 40);
    if (n >= 40) err_total++;
    bready <= 1'b0;
    // One idle edge so a following call never drives bready twice in one step
    @(posedge clk);
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [33:0] e);
    int n;
    q_r.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid && n < 40);
    if (n >= 40) err_total++;
    rready <= 1'b0;
    @(posedge clk);
  endtask

  function automatic logic [34:0] exp_meas(int a, b, c, n, bs, sl, bk, logic dsn);
    int d, bi, be, ex;
    d = a + b + c + n;
    bi = a;
    if (b > bi) bi = b;
    if (c > bi) bi = c;
    if (n > bi) bi = n;
    be = dsn ? bs * 4 : bs;
    ex = (bi > bk) ? bi - bk : 0;
    return {(100 * d > 100 * be + sl * ex), 18'(d), 16'(bi)};
  endfunction

  task automatic run_case(input logic op, dc, input int bs, sl, bk, a, b, c, n,
                          input logic dsn, ubn, drn);
    logic [34:0] m;
    axi_wr(ref_pkg::ADDR_CTRL, {30'h0, dc, op}, 2'h0);
    axi_wr(ref_pkg::ADDR_BASE, 32'(bs), 2'h0);
    axi_wr(ref_pkg::ADDR_SLOPE, 32'(sl), 2'h0);
    axi_wr(ref_pkg::ADDR_BRK, 32'(bk), 2'h0);
    m = exp_meas(a, b, c, n, bs, sl, bk, dsn);
    q_m.push_back(m);
    q_t.push_back(35'(m[34] & ~(ubn | (dc & drn)) & op));
    u_src.send(16'(a), 16'(b), 16'(c), 16'(n), dsn, ubn, drn);
  endtask

  function automatic int rnd(int m);
    return int'($unsigned($random(seed)) % m);
  endfunction

  initial begin
    #2500000;
    err_total++;
    final_report();
  end

  initial begin
    {resetn, awvalid, wvalid, bready, arvalid, rready, sv1, sv2} = 8'h0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hf;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    axi_rd(ref_pkg::ADDR_CTRL, 34'h3);
    axi_rd(ref_pkg::ADDR_BASE, 34'd30);
    axi_rd(ref_pkg::ADDR_SLOPE, 34'd70);
    axi_rd(ref_pkg::ADDR_BRK, 34'd125);
    axi_rd(ref_pkg::ADDR_DIFF, 34'h0);
    axi_rd(ref_pkg::ADDR_IRQ_MASK, 34'h0);
    $display("test reset values done");
    for (int i = 0; i < 3; i++) begin
      axi_wr(ref_pkg::ADDR_BASE + 8'(4 * i), 32'(lo[i] - 1), 2'h2);
      axi_wr(ref_pkg::ADDR_BASE + 8'(4 * i), 32'(hi[i] + 1), 2'h2);
      axi_wr(ref_pkg::ADDR_BASE + 8'(4 * i), 32'(lo[i]), 2'h0);
      axi_rd(ref_pkg::ADDR_BASE + 8'(4 * i), 34'(lo[i]));
      axi_wr(ref_pkg::ADDR_BASE + 8'(4 * i), 32'(hi[i]), 2'h0);
      axi_rd(ref_pkg::ADDR_BASE + 8'(4 * i), 34'(hi[i]));
    end
    axi_wr(ref_pkg::ADDR_STATUS, 32'h1, 2'h2);
    axi_wr(8'h24, 32'h1, 2'h2);
    axi_rd(8'h24, {2'h2, 32'h0});
    // A write without its low byte lane is answered but leaves the setting alone
    wstrb <= 4'h0;
    axi_wr(ref_pkg::ADDR_BASE, 32'h14, 2'h0);
    wstrb <= 4'hf;
    axi_rd(ref_pkg::ADDR_BASE, 34'd50);
    $display("test setting ranges done");
    // Boundary cases: equality never trips, one percent more does
    run_case(1, 1, 30, 70, 125, 30, 0, 0, 0, 0, 0, 0);
    run_case(1, 1, 30, 70, 125, 10, 10, 11, 0, 0, 0, 0);
    run_case(1, 1, 30, 70, 125, 100, 0, 20, 0, 1, 0, 0);
    run_case(1, 1, 30, 70, 125, 100, 0, 21, 0, 1, 0, 0);
    run_case(1, 1, 50, 70, 125, 150, 67, 0, 0, 1, 0, 0);
    run_case(1, 1, 50, 70, 125, 150, 68, 0, 0, 1, 0, 0);
    run_case(1, 0, 30, 70, 125, 0, 0, 0, 90, 0, 0, 1);
    run_case(1, 1, 30, 70, 125, 0, 0, 0, 90, 0, 0, 1);
    axi_rd(ref_pkg::ADDR_STATUS, 34'h6);
    run_case(1, 0, 30, 70, 125, 0, 0, 0, 90, 0, 1, 0);
    run_case(0, 1, 30, 70, 125, 0, 0, 0, 90, 0, 0, 0);
    axi_rd(ref_pkg::ADDR_DIFF, 34'd90);
    axi_rd(ref_pkg::ADDR_BIAS, 34'd90);
    $display("test directed characteristic done");
    repeat (40) begin
      run_case(rnd(4) != 0, rnd(2), 10 + rnd(41), 50 + rnd(51), 100 + rnd(101), rnd(160),
               rnd(160), rnd(160), rnd(160), rnd(2), rnd(4) == 0, rnd(3) == 0);
    end
    $display("test random characteristic done");
    run_case(1, 1, 30, 70, 125, 0, 0, 0, 0, 0, 0, 0);
    axi_wr(ref_pkg::ADDR_IRQ_STAT, 32'h3, 2'h0);
    axi_wr(ref_pkg::ADDR_IRQ_MASK, 32'h1, 2'h0);
    chk_irq(1'b0);
    run_case(1, 1, 30, 70, 125, 40, 0, 0, 0, 0, 0, 0);
    chk_irq(1'b1);
    axi_rd(ref_pkg::ADDR_IRQ_STAT, 34'h3);
    axi_wr(ref_pkg::ADDR_IRQ_STAT, 32'h1, 2'h0);
    axi_rd(ref_pkg::ADDR_IRQ_STAT, 34'h2);
    repeat (2) @(posedge clk);
    chk_irq(1'b0);
    axi_wr(ref_pkg::ADDR_IRQ_MASK, 32'h3, 2'h0);
    repeat (2) @(posedge clk);
    chk_irq(1'b1);
    $display("test interrupt done");
    // A reset in mid-run must clear the live outputs and the mask
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    chk_sig(35'h0, 35'({trip, chr, diff, irq}));
    @(posedge clk);
    axi_rd(ref_pkg::ADDR_BIAS, 34'h0);
    axi_rd(ref_pkg::ADDR_CTRL, 34'h3);
    axi_rd(ref_pkg::ADDR_IRQ_MASK, 34'h0);
    $display("test mid-run reset done");
    repeat (4) @(posedge clk);
    final_report();
  end
endmodule // ref_trip_top_tb
